// ===== rtl/irq_unit_pkg.sv
package irq_unit_pkg;

  // ------------------------------------------------------------
  // command codes and source numbering
  // ------------------------------------------------------------
  localparam logic [7:0] OP_SET_VECTOR = 8'h25;
  localparam logic [7:0] OP_ENABLE = 8'h19;
  localparam logic [7:0] OP_DISABLE = 8'h1A;
  localparam logic [7:0] OP_RETURN = 8'h26;
  localparam logic [7:0] SRC_GLOBAL = 8'hFF;
  localparam int NUM_SRC = 47;
  localparam int TIMER_BASE = 0;
  localparam int TARGET_BASE = 3;
  localparam int STALL_BASE = 15;
  localparam int LIMIT_BASE = 27;
  localparam int INCHG_BASE = 39;
  localparam int NUM_AXES = 6;
  localparam int NUM_TIMERS = 3;
  localparam int NUM_INPUTS = 8;

  // ------------------------------------------------------------
  // apb register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD_HEAD = 8'h00;
  localparam logic [7:0] ADDR_CMD_VALUE = 8'h04;
  localparam logic [7:0] ADDR_EN_LO = 8'h08;
  localparam logic [7:0] ADDR_EN_HI = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_ACCU = 8'h1C;
  localparam logic [7:0] ADDR_XREG = 8'h20;
  localparam logic [7:0] ADDR_FLAGS = 8'h24;
  localparam logic [7:0] ADDR_SET_HANDLER_VECTOR_SEL = 8'h28;
  localparam logic [7:0] ADDR_SET_HANDLER_VECTOR_DATA = 8'h2C;
  localparam logic [7:0] ADDR_PC = 8'h30;

  // irq status bits
  localparam int EV_ENTRY = 0;
  localparam int EV_RETURN = 1;
  localparam int EV_BADCMD = 2;
  localparam int EV_WIDTH = 3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] opcode;
    logic [7:0] kind;
    logic [7:0] bank;
    logic [31:0] value;
  } cmd_frame_t;

  typedef struct packed {
    logic [31:0] accu;
    logic [31:0] xreg;
    logic [7:0] flags;
  } cpu_ctx_t;

endpackage : irq_unit_pkg

// ===== rtl/irq_source_map.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// places raw event lines onto source numbers
// ------------------------------------------------------------
module irq_source_map
  import irq_unit_pkg::*;
(
  input wire logic [NUM_TIMERS-1:0] timer_i,
  input wire logic [NUM_AXES-1:0] target_i,
  input wire logic [NUM_AXES-1:0] stall_i,
  input wire logic [NUM_AXES-1:0] limit_left_i,
  input wire logic [NUM_AXES-1:0] limit_right_i,
  input wire logic [NUM_INPUTS-1:0] input_change_i,
  output logic [NUM_SRC-1:0] src_o
);
  always_comb begin
    src_o = '0;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      src_o[TIMER_BASE+i] = timer_i[i];
    end
    for (int a = 0; a < NUM_AXES; a++) begin
      src_o[TARGET_BASE+a] = target_i[a];
      src_o[STALL_BASE+a] = stall_i[a];
      src_o[LIMIT_BASE+2*a] = limit_left_i[a];
      src_o[LIMIT_BASE+2*a+1] = limit_right_i[a];
    end
    for (int k = 0; k < NUM_INPUTS; k++) begin
      src_o[INCHG_BASE+k] = input_change_i[k];
    end
  end
endmodule : irq_source_map
`default_nettype wire

// ===== rtl/irq_unit.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - command 37 stores a handler label for the source in the type byte
// - sources 0-2 are timers, 3-8 target reached of axes 0-5
// - sources 15-20 are stall events, 39-46 input changes 0-7
// - sources 27-38 are limit switches, left then right per axis
// - command 25 sets the enable of the named source
// - enable with source 255 sets the global enable
// - command 26 clears the enable of the named source
// - disable with source 255 clears the global enable
// - enable and disable take only the type byte
// - the label is the four operand bytes, most significant first
// - command 38 restores accumulator, x register and flags
module irq_unit
  import irq_unit_pkg::*;
#(
  parameter int LABEL_W = 32
)(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [NUM_TIMERS-1:0] TIMER_EV_I,
  input wire logic [NUM_AXES-1:0] TARGET_EV_I,
  input wire logic [NUM_AXES-1:0] STALL_EV_I,
  input wire logic [NUM_AXES-1:0] LIMIT_LEFT_I,
  input wire logic [NUM_AXES-1:0] LIMIT_RIGHT_I,
  input wire logic [NUM_INPUTS-1:0] INPUT_CHANGE_I,
  output logic IN_HANDLER_O,
  output logic [LABEL_W-1:0] PC_O,
  output logic IRQ_O
);
  // ------------------------------------------------------------
  // event inputs: two-stage sync, then edge detect
  // ------------------------------------------------------------
  logic [NUM_SRC-1:0] src_raw;
  logic [NUM_SRC-1:0] sync1;
  logic [NUM_SRC-1:0] sync2;
  logic [NUM_SRC-1:0] sync3;
  logic [NUM_SRC-1:0] pending;
  logic [NUM_SRC-1:0] src_en;
  logic [NUM_SRC-1:0] defined;
  logic global_en;
  logic in_handler;
  logic [LABEL_W-1:0] vector [NUM_SRC];
  cmd_frame_t cmd;
  cpu_ctx_t ctx;
  cpu_ctx_t saved;
  logic [LABEL_W-1:0] pc;
  logic [EV_WIDTH-1:0] irq_stat;
  logic [EV_WIDTH-1:0] irq_mask;
  logic [5:0] set_handler_vector_sel;

  irq_source_map u_map (
    .timer_i(TIMER_EV_I),
    .target_i(TARGET_EV_I),
    .stall_i(STALL_EV_I),
    .limit_left_i(LIMIT_LEFT_I),
    .limit_right_i(LIMIT_RIGHT_I),
    .input_change_i(INPUT_CHANGE_I),
    .src_o(src_raw)
  );

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= src_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // sources that exist; gaps in numbering stay zero
  always_comb begin
    defined = '0;
    for (int i = 0; i < TARGET_BASE + NUM_AXES; i++) defined[i] = 1'b1;
    for (int i = STALL_BASE; i < STALL_BASE + NUM_AXES; i++) begin
      defined[i] = 1'b1;
    end
    for (int i = LIMIT_BASE; i < NUM_SRC; i++) defined[i] = 1'b1;
  end

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic cmd_go;
  logic [7:0] src_num;
  logic src_ok;
  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_en = PSEL_I & PENABLE_I & ~PWRITE_I;
  // head write launches the frame; value must be written first
  assign cmd_go = wr_en & (PADDR_I == ADDR_CMD_HEAD);
  assign src_num = PWDATA_I[15:8];
  assign src_ok = (src_num < 8'(NUM_SRC)) && defined[src_num[5:0]];

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      cmd <= '0;
    end else if (wr_en && PADDR_I == ADDR_CMD_VALUE) begin
      cmd.value <= PWDATA_I;
    end else if (cmd_go) begin
      cmd.addr <= PWDATA_I[31:24];
      cmd.opcode <= PWDATA_I[23:16];
      cmd.kind <= PWDATA_I[15:8];
      cmd.bank <= PWDATA_I[7:0];
    end
  end

  // ------------------------------------------------------------
  // enables
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      src_en <= '0;
      global_en <= 1'b0;
    end else if (cmd_go && PWDATA_I[23:16] == OP_ENABLE) begin
      if (src_num == SRC_GLOBAL) global_en <= 1'b1;
      else if (src_ok) src_en[src_num[5:0]] <= 1'b1;
    end else if (cmd_go && PWDATA_I[23:16] == OP_DISABLE) begin
      if (src_num == SRC_GLOBAL) global_en <= 1'b0;
      else if (src_ok) src_en[src_num[5:0]] <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // vector table
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      // cleared so an unset entry reads as zero, never as unknown
      for (int i = 0; i < NUM_SRC; i++) vector[i] <= '0;
    end else if (cmd_go && PWDATA_I[23:16] == OP_SET_VECTOR && src_ok) begin
      vector[src_num[5:0]] <= LABEL_W'(cmd.value);
    end
  end

  // ------------------------------------------------------------
  // pending and dispatch
  // ------------------------------------------------------------
  logic [NUM_SRC-1:0] rise;
  logic [NUM_SRC-1:0] ready_src;
  logic take;
  logic [5:0] take_idx;
  logic do_return;
  assign rise = sync2 & ~sync3 & defined;
  assign ready_src = pending & src_en;
  assign do_return = cmd_go && PWDATA_I[23:16] == OP_RETURN && in_handler;
  always_comb begin
    take_idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (ready_src[i]) take_idx = 6'(i);
    end
  end
  // lowest number wins; one handler at a time
  assign take = global_en && |ready_src && !in_handler && !do_return;

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      pending <= '0;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        // a new event beats the clear of the one taken
        if (rise[i]) pending[i] <= 1'b1;
        else if (take && take_idx == 6'(i)) pending[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      in_handler <= 1'b0;
      saved <= '0;
      pc <= '0;
    end else if (take) begin
      in_handler <= 1'b1;
      saved <= ctx;
      pc <= vector[take_idx];
    end else if (do_return) begin
      in_handler <= 1'b0;
    end else if (wr_en && PADDR_I == ADDR_PC) begin
      pc <= LABEL_W'(PWDATA_I);
    end
  end

  // working context; software writes it, return restores it
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ctx <= '0;
    end else if (do_return) begin
      ctx <= saved;
    end else if (wr_en) begin
      case (PADDR_I)
        ADDR_ACCU: ctx.accu <= PWDATA_I;
        ADDR_XREG: ctx.xreg <= PWDATA_I;
        ADDR_FLAGS: ctx.flags <= PWDATA_I[7:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // interrupt status, mask, selector
  // ------------------------------------------------------------
  logic bad_cmd;
  assign bad_cmd = cmd_go && (PWDATA_I[23:16] == OP_RETURN ? !in_handler :
    (PWDATA_I[23:16] inside {OP_SET_VECTOR, OP_ENABLE, OP_DISABLE} &&
     !src_ok && !(PWDATA_I[23:16] != OP_SET_VECTOR &&
     src_num == SRC_GLOBAL)));
  logic [EV_WIDTH-1:0] ev;
  assign ev = {bad_cmd, do_return, take};
  logic stat_rd;
  assign stat_rd = rd_en && PADDR_I == ADDR_IRQ_STAT;
  // clear only what the reader was shown; an event that lands in the
  // setup cycle is not in the read data and must survive
  logic [EV_WIDTH-1:0] stat_keep;
  assign stat_keep = stat_rd ? irq_stat & ~PRDATA_O[EV_WIDTH-1:0] : irq_stat;

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      irq_stat <= '0;
    end else begin
      // set wins over the read clear
      irq_stat <= stat_keep | ev;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      irq_mask <= '0;
      set_handler_vector_sel <= '0;
    end else if (wr_en && PADDR_I == ADDR_IRQ_MASK) begin
      irq_mask <= PWDATA_I[EV_WIDTH-1:0];
    end else if (wr_en && PADDR_I == ADDR_SET_HANDLER_VECTOR_SEL) begin
      set_handler_vector_sel <= PWDATA_I[5:0];
    end
  end

  // ------------------------------------------------------------
  // read mux, registered outputs
  // ------------------------------------------------------------
  logic [31:0] rdata;
  logic addr_ok;
  always_comb begin
    rdata = '0;
    addr_ok = 1'b1;
    case (PADDR_I)
      ADDR_CMD_HEAD: rdata = {cmd.addr, cmd.opcode, cmd.kind, cmd.bank};
      ADDR_CMD_VALUE: rdata = cmd.value;
      ADDR_EN_LO: rdata = src_en[31:0];
      ADDR_EN_HI: rdata = 32'(src_en[NUM_SRC-1:32]);
      ADDR_STATUS: rdata = {30'h0, in_handler, global_en};
      ADDR_IRQ_STAT: rdata = 32'(irq_stat);
      ADDR_IRQ_MASK: rdata = 32'(irq_mask);
      ADDR_ACCU: rdata = ctx.accu;
      ADDR_XREG: rdata = ctx.xreg;
      ADDR_FLAGS: rdata = 32'(ctx.flags);
      ADDR_SET_HANDLER_VECTOR_SEL: rdata = 32'(set_handler_vector_sel);
      ADDR_SET_HANDLER_VECTOR_DATA: rdata = set_handler_vector_sel < 6'(NUM_SRC) ?
        32'(vector[set_handler_vector_sel]) : 32'h0;
      ADDR_PC: rdata = 32'(pc);
      default: addr_ok = 1'b0;
    endcase
  end

  // no wait state: ready is high in the first access cycle, right after setup
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      PREADY_O <= 1'b0;
      PRDATA_O <= '0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I & ~PENABLE_I;
      PRDATA_O <= rdata;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & ~addr_ok;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      IRQ_O <= 1'b0;
      IN_HANDLER_O <= 1'b0;
      PC_O <= '0;
    end else begin
      IRQ_O <= |(irq_stat & irq_mask);
      IN_HANDLER_O <= in_handler;
      PC_O <= pc;
    end
  end

endmodule : irq_unit
`default_nettype wire

// ===== sim/irq_unit_checker.sv
`timescale 1ns/100ps
`default_nettype none
module irq_unit_checker #(
  parameter int LABEL_W = 32
)(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic IN_HANDLER_O,
  input wire logic [LABEL_W-1:0] PC_O,
  input wire logic IRQ_O
);
  // ----------
  // bus and handler relations
  // ----------
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("pready longer than one cycle");
  ready_time_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("pready late");
  ready_access_a: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
    else $error("pready outside access");
  err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
    else $error("pslverr without pready");
  pc_entry_a: assert property ($changed(PC_O) |-> $rose(IN_HANDLER_O))
    else $error("pc moved outside entry");
  handler_exit_a: assert property ($fell(IN_HANDLER_O) |->
    $past(PREADY_O, 1) || $past(PREADY_O, 2))
    else $error("handler left without command");
  irq_drop_a: assert property ($fell(IRQ_O) |->
    $past(PREADY_O, 1) || $past(PREADY_O, 2) || $past(PREADY_O, 3))
    else $error("irq fell without access");
  irq_rise_a: assert property ($rose(IRQ_O) |-> $rose(IN_HANDLER_O) ||
    $past(PREADY_O, 1) || $past(PREADY_O, 2) || $past(PREADY_O, 3))
    else $error("irq rose without cause");
endmodule : irq_unit_checker
`default_nettype wire

// ===== sim/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model
  import irq_unit_pkg::*;
(
  input wire logic clk_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [31:0] prdata_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o
);
  logic [31:0] rdata;
  logic err;
  initial begin
    psel_o = 1'h0;
    penable_o = 1'h0;
    pwrite_o = 1'h0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
  end
  // pready is taken at the rising edge that ends the access, as the slave
  // sees it; the request is released only after that edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_o <= 1'h1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'h1;
    do @(posedge clk_i); while (pready_i !== 1'h1);
    rdata = prdata_i;
    err = pslverr_i;
    psel_o <= 1'h0;
    penable_o <= 1'h0;
  endtask : xfer
  // operand word first, the head launches the command
  task cmd(input logic [7:0] op, input logic [7:0] kind,
           input logic [7:0] bank, input logic [31:0] val);
    xfer(1'h1, ADDR_CMD_VALUE, val);
    xfer(1'h1, ADDR_CMD_HEAD, {8'h01, op, kind, bank});
  endtask : cmd
endmodule : host_model
`default_nettype wire

// ===== sim/irq_unit_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module irq_unit_tb_top
  import irq_unit_pkg::*;
;
  logic clk, rst, psel, pen, pwr, rdy, err, inh, irq;
  logic [7:0] padr;
  logic [31:0] pwd, prd, pc;
  logic [NUM_SRC-1:0] ev;
  logic [NUM_AXES-1:0] lft, rgt;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  always_comb begin
    for (int a = 0; a < NUM_AXES; a++) begin
      lft[a] = ev[LIMIT_BASE + 2 * a];
      rgt[a] = ev[LIMIT_BASE + 2 * a + 1];
    end
  end
  irq_unit u_irq_unit (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
    .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err),
    .TIMER_EV_I(ev[2:0]), .TARGET_EV_I(ev[8:3]),
    .STALL_EV_I(ev[20:15]), .INPUT_CHANGE_I(ev[46:39]),
    .LIMIT_LEFT_I(lft), .LIMIT_RIGHT_I(rgt), .IN_HANDLER_O(inh),
    .PC_O(pc), .IRQ_O(irq));
  host_model u_host_model (.clk_i(clk), .pready_i(rdy), .pslverr_i(err),
    .prdata_i(prd), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
    .paddr_o(padr), .pwdata_o(pwd));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wait_inh(input logic exp);
    for (int i = 0; i < 20 && inh !== exp; i++) @(posedge clk);
  endtask : wait_inh
  task t_map;
    u_host_model.cmd(OP_ENABLE, SRC_GLOBAL, 8'h00, 32'h0);
    for (int s = 0; s < NUM_SRC; s++) begin
      if (s inside {[9:14], [21:26]}) continue;
      u_host_model.cmd(OP_SET_VECTOR, s[7:0], 8'h5A,
        {8'hC3, s[7:0], 16'h5A0F});
      u_host_model.cmd(OP_ENABLE, s[7:0], 8'h03, 32'hFFFFFFFF);
      ev[s] <= 1'h1;
      wait_inh(1'h1);
      chk(32'(inh), 32'h1);
      chk(pc, {8'hC3, s[7:0], 16'h5A0F});
      ev[s] <= 1'h0;
      u_host_model.cmd(OP_RETURN, 8'h00, 8'h00, 32'h100);
      repeat (4) @(posedge clk);
      chk(32'(inh), 32'h0);
    end
    $display("test map done");
  endtask : t_map
  task t_gate;
    u_host_model.cmd(OP_DISABLE, 8'h03, 8'h07, 32'h7);
    ev[3] <= 1'h1;
    repeat (20) @(posedge clk);
    chk(32'(inh), 32'h0);
    u_host_model.cmd(OP_DISABLE, SRC_GLOBAL, 8'h00, 32'h0);
    u_host_model.cmd(OP_ENABLE, 8'h03, 8'h00, 32'h0);
    repeat (20) @(posedge clk);
    chk(32'(inh), 32'h0);
    u_host_model.cmd(OP_ENABLE, SRC_GLOBAL, 8'h00, 32'h0);
    wait_inh(1'h1);
    chk(pc, 32'hC3035A0F);
    ev[3] <= 1'h0;
    u_host_model.cmd(OP_RETURN, 8'h00, 8'h00, 32'h100);
    repeat (4) @(posedge clk);
    $display("test gate done");
  endtask : t_gate
  task t_bad;
    u_host_model.xfer(1'h0, ADDR_IRQ_STAT, 32'h0);
    u_host_model.cmd(OP_DISABLE, 8'h15, 8'h00, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    u_host_model.xfer(1'h1, ADDR_IRQ_MASK, 32'h4);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h1);
    u_host_model.xfer(1'h0, ADDR_IRQ_STAT, 32'h0);
    chk(u_host_model.rdata & 32'h4, 32'h4);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    u_host_model.cmd(OP_SET_VECTOR, 8'h09, 8'h00, 32'h12345678);
    u_host_model.xfer(1'h1, ADDR_SET_HANDLER_VECTOR_SEL, 32'h9);
    u_host_model.xfer(1'h0, ADDR_SET_HANDLER_VECTOR_DATA, 32'h0);
    chk(u_host_model.rdata, 32'h0);
    u_host_model.xfer(1'h0, 8'h3C, 32'h0);
    chk({31'h0, u_host_model.err}, 32'h1);
    chk(u_host_model.rdata, 32'h0);
    $display("test bad done");
  endtask : t_bad
  task t_ctx;
    u_host_model.xfer(1'h0, ADDR_EN_LO, 32'h0);
    chk(u_host_model.rdata, 32'hF81F81FF);
    u_host_model.xfer(1'h0, ADDR_EN_HI, 32'h0);
    chk(u_host_model.rdata, 32'h00007FFF);
    u_host_model.xfer(1'h1, ADDR_ACCU, 32'h11111111);
    u_host_model.xfer(1'h1, ADDR_XREG, 32'h22222222);
    u_host_model.xfer(1'h1, ADDR_FLAGS, 32'h5A);
    ev[40] <= 1'h1;
    wait_inh(1'h1);
    u_host_model.xfer(1'h0, ADDR_STATUS, 32'h0);
    chk(u_host_model.rdata, 32'h3);
    u_host_model.xfer(1'h1, ADDR_ACCU, 32'hDEADBEEF);
    u_host_model.xfer(1'h1, ADDR_FLAGS, 32'hA5);
    ev[40] <= 1'h0;
    u_host_model.cmd(OP_RETURN, 8'h00, 8'h00, 32'h100);
    u_host_model.xfer(1'h0, ADDR_ACCU, 32'h0);
    chk(u_host_model.rdata, 32'h11111111);
    u_host_model.xfer(1'h0, ADDR_XREG, 32'h0);
    chk(u_host_model.rdata, 32'h22222222);
    u_host_model.xfer(1'h0, ADDR_FLAGS, 32'h0);
    chk(u_host_model.rdata, 32'h5A);
    $display("test ctx done");
  endtask : t_ctx
  task t_reset;
    u_host_model.cmd(OP_SET_VECTOR, 8'h29, 8'h00, 32'h00000777);
    ev[41] <= 1'h1;
    wait_inh(1'h1);
    chk(pc, 32'h00000777);
    chk(32'(irq), 32'h1);
    ev[41] <= 1'h0;
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk({30'h0, inh, irq}, 32'h0);
    chk(pc, 32'h0);
    u_host_model.xfer(1'h0, ADDR_STATUS, 32'h0);
    chk(u_host_model.rdata, 32'h0);
    u_host_model.xfer(1'h0, ADDR_EN_LO, 32'h0);
    chk(u_host_model.rdata, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    rst = 1'h1;
    ev = '0;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    t_map();
    t_gate();
    t_bad();
    t_ctx();
    t_reset();
    finish_test();
  end
endmodule : irq_unit_tb_top
bind irq_unit irq_unit_checker #(.LABEL_W(LABEL_W)) u_irq_unit_checker (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .IN_HANDLER_O(IN_HANDLER_O), .PC_O(PC_O), .IRQ_O(IRQ_O));
`default_nettype wire
